// ==== hdl/srws_consts.vh ====
// What this block does
// - reset is held asserted whenever the supply-below-trip flag is true.
// - each reset lasts at least the reset timeout after its cause clears.
// - a new supply dip during the timeout restarts the timeout from zero.
// - a toggle input static longer than the watchdog timeout forces a reset.
// - with the watchdog disabled no watchdog reset is ever raised.
// - the active-high reset is always the inverse of the active-low reset.
// - the warning output goes low on the warning flag, with hysteresis in the comparator.
// - backup supply is selected only when below trip level and below backup level.
// - backup above main while main is above trip causes no reset and no switchover.
// - with the gate disabled the gated chip select is held high.
// - chip select passes while reset is released and is blocked during reset.
// - an active select at reset keeps the gate open until it ends or the window expires.
// - the watchdog timer clears on reset and on toggle edges and counts only out of reset.
// - in backup mode reset and warning stay asserted and the toggle input is ignored.
`ifndef SRWS_CONSTS_VH
`define SRWS_CONSTS_VH

`define SRWS_CLK_HZ        10000000
`define SRWS_RST_TIME_MS   200
`define SRWS_WDOG_TIME_MS  1600
`define SRWS_WRC_TIME_US   18
`define SRWS_CNT_W         25
`define SRWS_CNT_ZERO      25'h0000000
`define SRWS_CNT_ONE       25'h0000001

`endif

// ==== hdl/srws_supervisor.v ====
`timescale 1ns/1ps
`include "srws_consts.vh"

module srws_supervisor #(
	parameter integer CLK_HZ       = `SRWS_CLK_HZ,
	parameter integer RST_TIME_MS  = `SRWS_RST_TIME_MS,
	parameter integer WDOG_TIME_MS = `SRWS_WDOG_TIME_MS,
	parameter integer WRC_TIME_US  = `SRWS_WRC_TIME_US,
	// long counts are parameters so a simulation can shorten them
	parameter integer RST_CYCLES   = (CLK_HZ / 1000) * RST_TIME_MS,
	parameter integer WDOG_CYCLES  = (CLK_HZ / 1000) * WDOG_TIME_MS,
	parameter integer WRC_CYCLES   = (CLK_HZ / 1000000) * WRC_TIME_US
) (
	// clock and reset
	input  wire core_clk,
	input  wire rst_n,
	// comparator flags
	input  wire belowTripIn,
	input  wire belowBackupIn,
	input  wire belowWarnIn,
	// watchdog
	input  wire watchdog_toggle_in,
	input  wire watchdogDisableIn,
	// chip select
	input  wire chipSelInN,
	output reg  chipSelOutN,
	// supervisor outputs
	output reg  resetOutN,
	output reg  resetOut,
	output reg  early_supply_warning_n,
	output reg  backupSelOut
);

	// -----------------------------------------------------------------
	// constants
	// -----------------------------------------------------------------
	// counts are worked out at integer width, then cut to the counter width on purpose
	localparam integer           RST_LAST_I  = RST_CYCLES - 1;
	localparam integer           WDOG_LAST_I = WDOG_CYCLES - 1;
	localparam integer           WRC_LAST_I  = WRC_CYCLES - 1;
	localparam [`SRWS_CNT_W-1:0] RST_LAST    = RST_LAST_I[`SRWS_CNT_W-1:0];
	localparam [`SRWS_CNT_W-1:0] WDOG_LAST   = WDOG_LAST_I[`SRWS_CNT_W-1:0];
	localparam [`SRWS_CNT_W-1:0] WRC_LAST    = WRC_LAST_I[`SRWS_CNT_W-1:0];

	localparam [1:0] CS_PASS  = 2'h0;
	localparam [1:0] CS_WRITE = 2'h1;
	localparam [1:0] CS_BLOCK = 2'h2;

	function [`SRWS_CNT_W-1:0] cntInc;
		input [`SRWS_CNT_W-1:0] v;
		cntInc = v + `SRWS_CNT_ONE;
	endfunction

	// -----------------------------------------------------------------
	// synchronisers
	// -----------------------------------------------------------------
	// first stage feeds only the second
	reg [5:0] sync1_q;
	reg [5:0] sync2_q;
	reg       wdiPrev_q;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= {chipSelInN, watchdogDisableIn, watchdog_toggle_in,
				belowWarnIn, belowBackupIn, belowTripIn};
			sync2_q <= sync1_q;
		end
	end

	wire belowTrip   = sync2_q[0];
	wire belowBackup = sync2_q[1];
	wire belowWarn   = sync2_q[2];
	wire wdiSync     = sync2_q[3];
	wire wdogOff     = sync2_q[4];
	wire csInN       = sync2_q[5];

	// main above trip never reaches backup, whatever the backup level
	wire backupMode = belowTrip & belowBackup;

	// -----------------------------------------------------------------
	// reset timeout and watchdog
	// -----------------------------------------------------------------
	reg                   resetAct_q;
	reg [`SRWS_CNT_W-1:0] rstCnt_q;
	reg [`SRWS_CNT_W-1:0] wdogCnt_q;
	reg                   wdogFire;
	wire                  wdiEdge = (wdiSync != wdiPrev_q) & ~backupMode;

	always @* begin
		wdogFire = ~resetAct_q & ~wdogOff & ~backupMode & ~wdiEdge
			& (wdogCnt_q == WDOG_LAST);
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			resetAct_q <= 1'b1;
			rstCnt_q   <= `SRWS_CNT_ZERO;
			wdogCnt_q  <= `SRWS_CNT_ZERO;
			wdiPrev_q  <= 1'b0;
		end else begin
			wdiPrev_q <= wdiSync;
			if (belowTrip) begin
				resetAct_q <= 1'b1;
				rstCnt_q   <= `SRWS_CNT_ZERO;
			end else if (wdogFire) begin
				resetAct_q <= 1'b1;
				rstCnt_q   <= `SRWS_CNT_ZERO;
			end else if (resetAct_q) begin
				if (rstCnt_q == RST_LAST)
					resetAct_q <= 1'b0;
				else
					rstCnt_q <= cntInc(rstCnt_q);
			end
			// timer frozen at zero through reset, counts once released
			if (resetAct_q | belowTrip | wdogFire | wdiEdge | wdogOff)
				wdogCnt_q <= `SRWS_CNT_ZERO;
			else
				wdogCnt_q <= cntInc(wdogCnt_q);
		end
	end

	wire resetNext = belowTrip | wdogFire | (resetAct_q & ~(rstCnt_q == RST_LAST));

	// -----------------------------------------------------------------
	// chip-select gate
	// -----------------------------------------------------------------
	reg [1:0]             csState_q;
	reg [`SRWS_CNT_W-1:0] wrcCnt_q;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			csState_q <= CS_BLOCK;
			wrcCnt_q  <= `SRWS_CNT_ZERO;
		end else begin
			case (csState_q)
				CS_PASS: begin
					wrcCnt_q <= `SRWS_CNT_ZERO;
					if (resetNext) begin
						// a write in flight gets the completion window
						if (!csInN)
							csState_q <= CS_WRITE;
						else
							csState_q <= CS_BLOCK;
					end
				end
				CS_WRITE: begin
					wrcCnt_q <= cntInc(wrcCnt_q);
					if (csInN || wrcCnt_q == WRC_LAST)
						csState_q <= CS_BLOCK;
				end
				CS_BLOCK: begin
					wrcCnt_q <= `SRWS_CNT_ZERO;
					if (!resetNext)
						csState_q <= CS_PASS;
				end
				default: begin
					csState_q <= CS_BLOCK;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// registered outputs
	// -----------------------------------------------------------------
	// output follows the synchronised select, so it lags the pin by three cycles
	reg csGateOpen;

	always @* begin
		csGateOpen = 1'b0;
		case (csState_q)
			CS_PASS:  csGateOpen = ~resetNext | ~csInN;
			CS_WRITE: csGateOpen = ~csInN & (wrcCnt_q != WRC_LAST);
			default:  csGateOpen = 1'b0;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			resetOutN              <= 1'b0;
			resetOut               <= 1'b1;
			early_supply_warning_n <= 1'b0;
			backupSelOut           <= 1'b0;
			chipSelOutN            <= 1'b1;
		end else begin
			resetOutN              <= ~resetNext;
			resetOut               <= resetNext;
			early_supply_warning_n <= ~(belowWarn | backupMode);
			backupSelOut           <= backupMode;
			chipSelOutN            <= csGateOpen ? csInN : 1'b1;
		end
	end

endmodule // srws_supervisor

// ==== tb/srws_assertions.sv ====
`timescale 1ns/1ps
module srws_checker (
	// watched ports
	input wire core_clk,
	input wire rst_n,
	input wire belowTripIn,
	input wire belowBackupIn,
	input wire belowWarnIn,
	input wire chipSelInN,
	input wire chipSelOutN,
	input wire resetOutN,
	input wire resetOut,
	input wire early_supply_warning_n,
	input wire backupSelOut
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_inv; resetOut == !resetOutN; endproperty
	a_inv: assert property (p_inv) else $error("reset pair not inverse");
	property p_trip; belowTripIn |-> ##3 !resetOutN; endproperty
	a_trip: assert property (p_trip) else $error("no reset on trip");
	property p_hold; $fell(resetOutN) |=> !resetOutN [*8]; endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_bak; (belowTripIn && belowBackupIn) [*4] |-> backupSelOut && !early_supply_warning_n;
	endproperty
	a_bak: assert property (p_bak) else $error("backup mode wrong");
	property p_nobak; (!belowTripIn) [*4] |-> !backupSelOut; endproperty
	a_nobak: assert property (p_nobak) else $error("backup above trip");
	property p_warn; belowWarnIn [*4] |-> !early_supply_warning_n; endproperty
	a_warn: assert property (p_warn) else $error("warning missing");
	property p_cs; resetOutN [*4] |-> chipSelOutN == $past(chipSelInN, 3); endproperty
	a_cs: assert property (p_cs) else $error("select not passed");
	// window plus latency fit in eight cycles
	property p_gate; (!resetOutN) [*8] |-> chipSelOutN; endproperty
	a_gate: assert property (p_gate) else $error("select not gated");
	c_rst: cover property ($fell(resetOutN) && !belowTripIn);
	c_bak: cover property ($rose(backupSelOut));
	c_gate: cover property ($rose(chipSelOutN) && !resetOutN);
endmodule // srws_checker
bind srws_supervisor srws_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.belowTripIn(belowTripIn), .belowBackupIn(belowBackupIn), .belowWarnIn(belowWarnIn),
	.chipSelInN(chipSelInN), .chipSelOutN(chipSelOutN), .resetOutN(resetOutN),
	.resetOut(resetOut), .early_supply_warning_n(early_supply_warning_n),
	.backupSelOut(backupSelOut));

// ==== tb/srws_host.sv ====
`timescale 1ns/1ps
module srws_host (
	input  wire core_clk,
	input  wire resetOutN,
	input  wire early_supply_warning_n,
	input  wire kickEn,
	input  wire csReq,
	output reg  watchdog_toggle_in = 1'b0,
	output reg  chipSelInN = 1'b1
);
	reg [3:0] tick_q = 4'h0;
	always @(posedge core_clk) begin
		tick_q <= tick_q + 4'h1;
		// code runs only out of reset, so kicks stop during reset
		if (kickEn && resetOutN && tick_q == 4'hF)
			watchdog_toggle_in <= !watchdog_toggle_in;
		chipSelInN <= !(csReq && early_supply_warning_n);
	end
endmodule // srws_host

// ==== tb/srws_supervisor_tb.sv ====
`timescale 1ns/1ps
module srws_supervisor_tb;
	reg     core_clk = 1'b0, rst_n = 1'b0, trip = 1'b0, bak = 1'b0, warn = 1'b0;
	reg     wdOff = 1'b0, kickEn = 1'b1, csReq = 1'b0;
	wire    wdIn, csInN, csOutN, rstOutN, rstOut, warnN, bakSel;
	integer fail_count = 0, n_tests = 0, cyc = 0, seed = 32'h94355e63, i;
	srws_supervisor #(.RST_CYCLES(20), .WDOG_CYCLES(50), .WRC_CYCLES(5)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .belowTripIn(trip), .belowBackupIn(bak),
		.belowWarnIn(warn), .watchdog_toggle_in(wdIn), .watchdogDisableIn(wdOff),
		.chipSelInN(csInN), .chipSelOutN(csOutN), .resetOutN(rstOutN), .resetOut(rstOut),
		.early_supply_warning_n(warnN), .backupSelOut(bakSel));
	srws_host u_host (.core_clk(core_clk), .resetOutN(rstOutN), .early_supply_warning_n(warnN),
		.kickEn(kickEn), .csReq(csReq), .watchdog_toggle_in(wdIn), .chipSelInN(csInN));
	always #50 core_clk = !core_clk;
	function eBak(input t, input b); eBak = t & b; endfunction
	function eWarn(input w, input t, input b); eWarn = !(w | (t & b)); endfunction
	task w(input integer n); repeat (n) @(posedge core_clk); endtask
	task chk(input string nm, input e, input g);
		#1 n_tests = n_tests + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("[ERR] %0s exp %b got %b", nm, e, g);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count = fail_count + 1;
			tally_and_finish;
		end
	end
	initial begin
		w(12); rst_n <= 1'b1;
		w(10); chk("pwrup", 0, rstOutN);
		w(25); chk("pwrup", 1, rstOutN);
		$display("test power-up done");
		w(1); trip <= 1'b1; w(5); trip <= 1'b0;
		w(12); chk("dip", 0, rstOutN);
		w(1); trip <= 1'b1; w(2); trip <= 1'b0;
		w(18); chk("restart", 0, rstOutN);
		w(10); chk("restart", 1, rstOutN);
		$display("test dip done");
		w(1); kickEn <= 1'b0;
		for (i = 0; i < 100 && rstOutN; i = i + 1) w(1);
		chk("wdog", 1, i >= 30 && i <= 60);
		kickEn <= 1'b1; w(30); chk("wdog", 1, rstOutN);
		w(1); wdOff <= 1'b1; kickEn <= 1'b0; w(150); chk("wdoff", 1, rstOutN);
		w(1); kickEn <= 1'b1; w(20); wdOff <= 1'b0;
		$display("test watchdog done");
		w(1); csReq <= 1'b1; w(5); chk("csPass", 0, csOutN);
		w(1); trip <= 1'b1; w(4); chk("csWin", 0, csOutN);
		w(8); chk("csGate", 1, csOutN);
		w(1); bak <= 1'b1; w(6); chk("bak", eBak(1, 1), bakSel);
		chk("bakWarn", eWarn(0, 1, 1), warnN);
		w(1); trip <= 1'b0; w(4); chk("bakHi", eBak(0, 1), bakSel);
		w(1); csReq <= 1'b0; w(30); chk("bakHi", 1, rstOutN);
		$display("test backup done");
		for (i = 0; i < 300; i = i + 1) begin
			w(1); csReq <= ($random(seed) & 1) != 0; bak <= ($random(seed) & 1) != 0;
			warn <= ($random(seed) & 7) == 0;
		end
		w(1); warn <= 1'b0; w(6); chk("rnd", eWarn(0, 0, bak), warnN);
		chk("rnd", 1, rstOutN);
		$display("test random done");
		tally_and_finish;
	end
endmodule // srws_supervisor_tb
